// ---- logic/odp_output_dep.sv ----
// second product term and assertion logic for one sequenced output
// Notes on behaviour
// - 0x27 bits 0-3 select primary undervoltage of inputs one to four.
// - 0x27 bits 4-5 select inputs five, six; zero on four-input part.
// - 0x27 bits 6-7 select watchdog one and two.
// - 0x28 bits 0-3 select secondary threshold of inputs one to four.
// - 0x28 bits 4-5 select secondary of inputs five, six; six-input only.
// - 0x28 bits 6-7 and 0x29 bits 0-1 select logic inputs one to four.
// - 0x29 bits 2-3 select outputs one, two; six-input only.
// - 0x29 bits 4-7 select four other outputs, mapping by variant.
// - 0x3B bit 4 selects output eight; six-input only.
// - 0x40 bit 4 set: output asserts while manual reset is low.
// - output deasserts when either product term is one, unless the 0x40 manual reset holds it asserted.
// - first product term arrives as a result from elsewhere.
module odp_output_dep
(
  // clock and reset
  input  wire logic              CLK_I,
  input  wire logic              RST_I,
  // variant strap, 1 = six-input part
  input  wire logic              SIX_INPUT_I,
  // condition levels from pins
  input  wire odp_pkg::odp_cond_t COND_I,
  // first product term result
  input  wire logic              TERM1_I,
  // configuration register port
  input  wire odp_pkg::odp_reg_req_t REG_I,
  output logic [7:0]             REG_RDATA_O,
  output logic                   REG_RVALID_O,
  // results
  output logic                   TERM2_O,
  output logic                   OUT_ASSERT_O
);

  import odp_pkg::*;

  odp_cond_t              sync1_q;
  odp_cond_t              sync2_q;
  odp_cond_t              sync3_q;
  odp_cond_t              stab_q;
  logic [7:0]             m27_q;
  logic [7:0]             m28_q;
  logic [7:0]             m29_q;
  logic [7:0]             m3b_q;
  logic [7:0]             m40_q;
  logic                   six_q;
  logic                   strap_done_q;
  logic [7:0]             mask_pw;
  logic [7:0]             mask_sg;
  logic [ODP_DEP_W-1:0]   dep_mask;
  logic [ODP_DEP_W-1:0]   dep_fault;
  logic [6:0]             out_mask;
  logic [6:0]             out_fault;
  logic                   term2_c;
  logic                   mr_force;
  logic [7:0]             rdata_d;

  // three-stage capture of pin levels
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      sync1_q <= '0;
      sync2_q <= '0;
      sync3_q <= '0;
      // idle pin level is high, no false press after reset
      sync1_q.mr_n <= 1'b1;
      sync2_q.mr_n <= 1'b1;
      sync3_q.mr_n <= 1'b1;
    end else begin
      sync1_q <= COND_I;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end

  // accept a level once the last two stages agree, per bit
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      stab_q      <= '0;
      stab_q.mr_n <= 1'b1;
    end else begin
      for (int i = 0; i < ODP_COND_W; i++) begin
        if (sync2_q[i] == sync3_q[i]) begin
          stab_q[i] <= sync3_q[i];
        end
      end
    end
  end

  // variant strap caught once after reset release
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      six_q        <= 1'b1;
      strap_done_q <= 1'b0;
    end else if (!strap_done_q) begin
      six_q        <= SIX_INPUT_I;
      strap_done_q <= 1'b1;
    end
  end

  // configuration register writes
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      m27_q <= ODP_REG_RESET;
      m28_q <= ODP_REG_RESET;
      m29_q <= ODP_REG_RESET;
      m3b_q <= ODP_REG_RESET;
      m40_q <= ODP_REG_RESET;
    end else if (REG_I.wr) begin
      case (REG_I.addr)
        ODP_OFS_PRIM_WD: begin
          m27_q <= REG_I.wdata;
        end
        ODP_OFS_SEC_GPI: begin
          m28_q <= REG_I.wdata;
        end
        ODP_OFS_GPI_OUT: begin
          m29_q <= REG_I.wdata;
        end
        ODP_OFS_OUT_EGT: begin
          m3b_q <= REG_I.wdata;
        end
        ODP_OFS_MR_EN: begin
          m40_q <= REG_I.wdata;
        end
        default: begin
        end
      endcase
    end
  end

  // register read mux
  always_comb begin
    case (REG_I.addr)
      ODP_OFS_PRIM_WD: rdata_d = m27_q;
      ODP_OFS_SEC_GPI: rdata_d = m28_q;
      ODP_OFS_GPI_OUT: rdata_d = m29_q;
      ODP_OFS_OUT_EGT: rdata_d = m3b_q;
      ODP_OFS_MR_EN:   rdata_d = m40_q;
      ODP_OFS_STATUS: begin
        rdata_d                = ODP_RD_UNMAPPED;
        rdata_d[ODP_ST_TERM2]  = TERM2_O;
        rdata_d[ODP_ST_ASSERT] = OUT_ASSERT_O;
        rdata_d[ODP_ST_SIX]    = six_q;
      end
      default:         rdata_d = ODP_RD_UNMAPPED;
    endcase
  end

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      REG_RDATA_O  <= ODP_RD_UNMAPPED;
      REG_RVALID_O <= 1'b0;
    end else begin
      REG_RDATA_O  <= REG_I.rd ? rdata_d : ODP_RD_UNMAPPED;
      REG_RVALID_O <= REG_I.rd;
    end
  end

  // fifth/sixth inputs dropped on four-input part
  always_comb begin
    mask_pw = odp_clean_mask(m27_q, six_q);
    mask_sg = odp_clean_mask(m28_q, six_q);
  end

  always_comb begin
    out_mask = {m3b_q[ODP_OUT8_BIT], m29_q[ODP_OUTX_HI:ODP_OUTX_LO],
                m29_q[ODP_OUT12_HI:ODP_OUT12_LO]};
    if (six_q) begin
      out_fault = {stab_q.outs[7], stab_q.outs[6], stab_q.outs[5],
                   stab_q.outs[3], stab_q.outs[2], stab_q.outs[1],
                   stab_q.outs[0]};
    end else begin
      out_mask[6] = 1'b0;
      out_mask[1:0] = 2'b00;
      out_fault = {1'b0, stab_q.outs[4], stab_q.outs[3],
                   stab_q.outs[1], stab_q.outs[0], 2'b00};
    end
  end

  always_comb begin
    dep_mask  = {mask_pw[7:6], mask_pw[5:0], mask_sg[5:0],
                 m29_q[ODP_GPI34_HI:ODP_GPI34_LO], mask_sg[7:6],
                 out_mask};
    dep_fault = {stab_q.wdog[1], stab_q.wdog[0], stab_q.prim,
                 stab_q.sec, stab_q.gpi[3:2], stab_q.gpi[1:0],
                 out_fault};
  end

  odp_term_eval u_term2 (
    .mask_i  (dep_mask),
    .fault_i (dep_fault),
    .prod_o  (term2_c)
  );

  always_comb begin
    mr_force = m40_q[ODP_MR_BIT] && !stab_q.mr_n;
  end

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      TERM2_O      <= 1'b0;
      OUT_ASSERT_O <= 1'b1;
    end else begin
      TERM2_O      <= term2_c;
      OUT_ASSERT_O <= mr_force || !(term2_c || TERM1_I);
    end
  end

  // checks
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RST_I);

  sequence s_mr_steady;
    $stable(COND_I.mr_n) [*4];
  endsequence

  sequence s_mr_pressed;
    m40_q[ODP_MR_BIT] && !stab_q.mr_n;
  endsequence

  a_mr_forces_out: assert property (
    s_mr_pressed |=> OUT_ASSERT_O)
    else $error("manual reset did not assert output");

  a_pin_settles: assert property (
    s_mr_steady |=> (stab_q.mr_n == $past(COND_I.mr_n)))
    else $error("steady pin level not accepted in time");

  a_term_release: assert property (
    ((term2_c || TERM1_I) && !mr_force) |=> !OUT_ASSERT_O)
    else $error("output held although a term is one");

  a_term1_joins: assert property (
    (TERM1_I && !term2_c && !mr_force) |=> !OUT_ASSERT_O && !TERM2_O)
    else $error("first term result not honoured");

  a_both_low: assert property (
    (!term2_c && !TERM1_I) |=> OUT_ASSERT_O)
    else $error("output not asserted with both terms zero");

  a_empty_mask: assert property (
    (dep_mask == '0) |=> TERM2_O)
    else $error("empty mask did not give a true term");

  a_prim_fault: assert property (
    (m27_q[0] && stab_q.prim[0]) |-> !term2_c)
    else $error("primary fault ignored");

  a_hi_masked: assert property (
    (!six_q && stab_q.prim[ODP_HI_IN_LO] && m28_q == '0 && m29_q == '0
     && m3b_q == '0 && m27_q[3:0] == '0 && m27_q[7:6] == '0)
    |-> term2_c)
    else $error("fifth input used on four-input part");

  a_wdog_fault: assert property (
    (m27_q[7] && stab_q.wdog[1]) |=> !TERM2_O)
    else $error("watchdog two fault ignored");

  a_sec_fault: assert property (
    (m28_q[3] && stab_q.sec[3]) |-> !term2_c)
    else $error("secondary fault ignored");

  a_sec_hi_masked: assert property (
    !six_q |-> (dep_mask[16:15] == 2'b00 && dep_mask[22:21] == 2'b00))
    else $error("high inputs selectable on four-input part");

  a_gpi_fault: assert property (
    (m29_q[ODP_GPI34_HI] && stab_q.gpi[3]) |-> !term2_c)
    else $error("logic input four fault ignored");

  a_out12_masked: assert property (
    !six_q |-> (dep_mask[1:0] == 2'b00))
    else $error("outputs one/two selectable on four-input part");

  a_outx_map: assert property (
    (m29_q[ODP_OUTX_LO] && (six_q ? stab_q.outs[2] : stab_q.outs[0]))
    |-> !term2_c)
    else $error("other output mapping wrong");

  a_out8_masked: assert property (
    !six_q |-> !dep_mask[6])
    else $error("output eight selectable on four-input part");

  a_mr_ignored: assert property (
    (!m40_q[ODP_MR_BIT] && term2_c) |=> !OUT_ASSERT_O)
    else $error("manual reset honoured while not selected");

  a_wdog_one: assert property (
    (m27_q[6] && stab_q.wdog[0]) |-> !term2_c)
    else $error("watchdog one fault ignored");

  a_gpi_one: assert property (
    (m28_q[6] && stab_q.gpi[0]) |-> !term2_c)
    else $error("logic input one fault ignored");

  a_out8_map: assert property (
    (six_q && m3b_q[ODP_OUT8_BIT] && stab_q.outs[7]) |-> !term2_c)
    else $error("output eight fault ignored");

endmodule : odp_output_dep

// ---- logic/odp_pkg.sv ----
// package: constants, types and helpers for the second dependency term
package odp_pkg;

  // register offsets of the configuration block
  localparam logic [7:0] ODP_OFS_PRIM_WD  = 8'h27;
  localparam logic [7:0] ODP_OFS_SEC_GPI  = 8'h28;
  localparam logic [7:0] ODP_OFS_GPI_OUT  = 8'h29;
  localparam logic [7:0] ODP_OFS_OUT_EGT  = 8'h3B;
  localparam logic [7:0] ODP_OFS_MR_EN    = 8'h40;
  localparam logic [7:0] ODP_OFS_STATUS   = 8'hF0;

  localparam logic [7:0] ODP_REG_RESET    = 8'h00;
  localparam logic [7:0] ODP_RD_UNMAPPED  = 8'h00;

  // field positions
  localparam int ODP_HI_IN_LO   = 4;
  localparam int ODP_HI_IN_HI   = 5;
  localparam int ODP_OUT12_LO   = 2;
  localparam int ODP_OUT12_HI   = 3;
  localparam int ODP_OUTX_LO    = 4;
  localparam int ODP_OUTX_HI    = 7;
  localparam int ODP_GPI34_LO   = 0;
  localparam int ODP_GPI34_HI   = 1;
  localparam int ODP_OUT8_BIT   = 4;
  localparam int ODP_MR_BIT     = 4;
  localparam int ODP_ST_TERM2   = 0;
  localparam int ODP_ST_ASSERT  = 1;
  localparam int ODP_ST_SIX     = 2;

  // widths of the combined dependency vector and of the condition struct
  localparam int ODP_DEP_W      = 25;
  localparam int ODP_COND_W     = 27;

  // fault levels of every condition, 1 = fault / asserted, except mr_n, which is low while pressed
  typedef struct packed {
    logic [5:0] prim;
    logic [5:0] sec;
    logic [1:0] wdog;
    logic [3:0] gpi;
    logic [7:0] outs;
    logic       mr_n;
  } odp_cond_t;

  typedef struct packed {
    logic [7:0] addr;
    logic       wr;
    logic       rd;
    logic [7:0] wdata;
  } odp_reg_req_t;

  // clear the fifth/sixth input bits on the four-input variant
  function automatic logic [7:0] odp_clean_mask(input logic [7:0] v,
                                                input logic       six);
    logic [7:0] r;
    r = v;
    if (!six) begin
      r[ODP_HI_IN_HI:ODP_HI_IN_LO] = 2'b00;
    end
    return r;
  endfunction : odp_clean_mask

endpackage : odp_pkg

// ---- logic/odp_term_eval.sv ----
// product term evaluator over a dependency mask
module odp_term_eval
  import odp_pkg::*;
(
  // mask and fault levels
  input  wire logic [ODP_DEP_W-1:0] mask_i,
  input  wire logic [ODP_DEP_W-1:0] fault_i,
  // result
  output logic                      prod_o
);

  // true only when every selected condition is free of fault
  always_comb begin
    prod_o = &(~mask_i | ~fault_i);
  end

endmodule : odp_term_eval

// ---- verif/odp_output_dep_tb_top.sv ----
// testbench for the second dependency term of one sequenced output
module odp_output_dep_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import odp_pkg::*;
  logic         clk = 1'b0;
  logic         rst = 1'b1;
  logic         six = 1'b1;
  logic [26:0]  lvl = 27'h1;
  logic         t1  = 1'b0;
  odp_reg_req_t req = '0;
  odp_cond_t    cond;
  logic         t1_pin;
  logic [7:0]   rdata;
  logic         rvalid;
  logic         term2;
  logic         oa;
  int           err_count = 0;
  int           compares = 0;
  int           cyc = 0;
  int           pos [25] = '{21, 22, 23, 24, 25, 26, 13, 14, 15, 16, 17, 18,
                             19, 20, 9, 10, 11, 12, 1, 2, 3, 4, 6, 7, 8};
  logic [7:0]   a;
  int           b;

  always #2.5 clk = ~clk;

  odp_supply_model u_model (.clk_i(clk), .lvl_i(lvl), .term1_i(t1),
                            .cond_o(cond), .term1_o(t1_pin));
  odp_output_dep dut (.CLK_I(clk), .RST_I(rst), .SIX_INPUT_I(six),
                      .COND_I(cond), .TERM1_I(t1_pin), .REG_I(req),
                      .REG_RDATA_O(rdata), .REG_RVALID_O(rvalid),
                      .TERM2_O(term2), .OUT_ASSERT_O(oa));

  task automatic finish_test;
    $display("Checks %0d errors %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : finish_test

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] ad, input logic [7:0] d);
    @(posedge clk);
    req.addr  <= ad;
    req.wdata <= d;
    req.wr    <= 1'b1;
    @(posedge clk);
    req.wr    <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] ad, input logic [7:0] exp);
    @(posedge clk);
    req.addr <= ad;
    req.rd   <= 1'b1;
    @(posedge clk);
    req.rd   <= 1'b0;
    #1;
    chk({7'h0, rvalid}, 8'h01);
    chk(rdata, exp);
  endtask : rd

  task automatic set_lvl(input logic [26:0] v, input logic t);
    @(posedge clk);
    lvl <= v;
    t1  <= t;
  endtask : set_lvl

  // pins pass a synchroniser, so allow the full latency
  task automatic outs(input logic t2, input logic asr);
    repeat (6) @(posedge clk);
    #1;
    chk({6'h0, term2, oa}, {6'h0, t2, asr});
  endtask : outs

  task automatic do_reset(input logic s);
    @(posedge clk);
    rst <= 1'b1;
    six <= s;
    lvl <= 27'h1;
    repeat (2) @(posedge clk);
    #1;
    chk({6'h0, term2, oa}, 8'h01);
    @(posedge clk);
    rst <= 1'b0;
  endtask : do_reset

  always @(posedge clk) begin
    cyc++;
    if (cyc == 4000) begin
      err_count++;
      finish_test();
    end
  end

  initial begin
    do_reset(1'b1);
    foreach (pos[i]) begin
      a = (i < 8) ? 8'h27 : (i < 16) ? 8'h28 : (i < 24) ? 8'h29 : 8'h3B;
      b = (i == 24) ? 4 : i % 8;
      rd(a, 8'h00);
      wr(a, 8'h01 << b);
      set_lvl(27'h1 | (27'h1 << pos[i]), 1'b0);
      outs(1'b0, 1'b1);
      set_lvl(~(27'h1 << pos[i]), 1'b0);
      outs(1'b1, 1'b0);
      set_lvl(27'h1 | (27'h1 << pos[i]), 1'b0);
      rd(a, 8'h01 << b);
      wr(a, 8'h00);
      outs(1'b1, 1'b0);
    end
    wr(8'h27, 8'h01);
    set_lvl(27'h1 << 21 | 27'h1, 1'b1);
    outs(1'b0, 1'b0);
    set_lvl(27'h1 << 21 | 27'h1, 1'b0);
    outs(1'b0, 1'b1);
    wr(8'h40, 8'h10);
    set_lvl(27'h0, 1'b0);
    outs(1'b1, 1'b1);
    wr(8'h40, 8'h00);
    outs(1'b1, 1'b0);
    wr(8'h55, 8'hFF);
    rd(8'h55, 8'h00);
    // status is read-only: term2 high, output released, six-input part
    wr(8'hF0, 8'hFF);
    rd(8'hF0, 8'h05);
    do_reset(1'b0);
    rd(8'h40, 8'h00);
    // four-input part: host keeps the fifth/sixth input bits at zero
    wr(8'h27, 8'h01);
    set_lvl(27'h1 << 25 | 27'h1, 1'b0);
    outs(1'b1, 1'b0);
    rd(8'h27, 8'h01);
    // output one/two bits kept at zero, bit 4 maps to the first output
    wr(8'h29, 8'h10);
    set_lvl(27'h1 << 2 | 27'h1, 1'b0);
    outs(1'b1, 1'b0);
    set_lvl(27'h1 << 1 | 27'h1, 1'b0);
    outs(1'b0, 1'b1);
    rd(8'hF0, 8'h02);
    finish_test();
  end
endmodule : odp_output_dep_tb_top

// ---- verif/odp_supply_model.sv ----
// far-side model: supply, watchdog and reset levels at the block
module odp_supply_model
  import odp_pkg::*;
(
  // clock
  input  wire logic         clk_i,
  // wanted levels from the bench
  input  wire logic [26:0]  lvl_i,
  input  wire logic         term1_i,
  // levels towards the block
  output odp_pkg::odp_cond_t cond_o,
  output logic              term1_o
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    cond_o  = 27'h1;
    term1_o = 1'b0;
  end
  // levels only move just after an edge, then hold
  always @(posedge clk_i) begin
    cond_o  <= lvl_i;
    term1_o <= term1_i;
  end
endmodule : odp_supply_model
